// file: verilog/sfp_pkg.sv
// Constants shared by the serial flash pin interface and its byte FIFO.
// Assumes a host that drives the serial clock in mode 0 or mode 3.
// Functional notes
// - Read data bit changes after each falling serial clock edge on the primary output.
// - Dual, quad and quad program modes turn the primary output into input lane 1.
// - Command, address and program bits are sampled on each rising serial clock edge.
// - Dual and quad reads drive the primary input as output lane 0.
// - Select low means active; select high deselects and floats outputs.
// - No command is accepted until a select falling edge follows power-up.
// - Standby only when no program, erase or register write is running.
// - Pause low suspends the transfer, floats outputs, ignores clock and data.
// - Quad transfers use pause pin as lane 3 and write-protect pin as lane 2.
// - Write-protect low blocks program and erase in the block-protected area.
// - Works in mode 0 and mode 3; idle clock level equals polarity.
// - Data moves in whole bytes; clock may stop while selected.
package sfp_pkg;
  localparam int SFP_BYTE_BITS = 8;
  localparam int SFP_FIFO_DEPTH = 8;
  localparam logic [2:0] SFP_BP_RESET = 3'h0;
  localparam logic [3:0] SFP_CNT_SEED = 4'h0;
  typedef enum logic [1:0] {
    SFP_LANE_SINGLE,
    SFP_LANE_DUAL,
    SFP_LANE_QUAD
  } sfp_lanes_e;
  typedef enum {
    SFP_ST_IDLE,
    SFP_ST_IN,
    SFP_ST_OUT
  } sfp_state_e;
endpackage : sfp_pkg

// file: verilog/sfp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Handshakes and pointer advance.
  always_comb begin
    in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    out_valid_o = (cnt_r != '0);
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_nxt = push ? AW'((wr_r + 1'b1) % DEPTH) : wr_r;
    rd_nxt = pop ? AW'((rd_r + 1'b1) % DEPTH) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointer and count registers.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage is written without reset; only valid entries are ever read.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  assign out_data_o = mem_r[rd_r];
endmodule : sfp_fifo

// file: verilog/sfp_pins.sv
// Pin-level serial front end of a serial flash: samples the link, shifts bytes in
// and out over one, two or four lanes, and applies select, pause and write-protect.
// Assumes the command decoder sets the lane mode, direction and busy state, and
// that received bytes are drained through the FIFO output ports.
`timescale 1ns/1ps
module sfp_pins
  import sfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic data_in_lane0_i,
  output logic data_in_lane0_o,
  output logic data_in_lane0_oe_o,
  input wire logic data_out_lane1_i,
  output logic data_out_lane1_o,
  output logic data_out_lane1_oe_o,
  input wire logic write_protect_n_lane2_i,
  output logic write_protect_n_lane2_o,
  output logic write_protect_n_lane2_oe_o,
  input wire logic pause_n_lane3_i,
  output logic pause_n_lane3_o,
  output logic pause_n_lane3_oe_o,
  input wire logic [1:0] lane_mode_i,
  input wire logic read_phase_i,
  input wire logic quad_program_i,
  input wire logic internal_busy_i,
  input wire logic [2:0] block_protect_field_i,
  input wire logic srwd_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic rx_overflow_o,
  output logic armed_o,
  output logic active_o,
  output logic standby_o,
  output logic program_blocked_o,
  output logic status_locked_o
);
  // Two-flop synchronisers for every pin that is read as a control or data input.
  // Select resets low, so a select held low through reset is never taken for a falling edge.
  // Pause and protect reset to their inactive high level, so nothing is blocked right after reset.
  logic [5:0] s1_r, s2_r, s3_r;
  logic [5:0] pins_raw;
  assign pins_raw = {pause_n_lane3_i, write_protect_n_lane2_i, data_out_lane1_i,
                     data_in_lane0_i, cs_n_i, sck_i};
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_r <= 6'h31;
      s2_r <= 6'h31;
      s3_r <= 6'h31;
    end else begin
      s1_r <= pins_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic sck_s, cs_n_s, pause_n_s, wp_n_s;
  logic [3:0] lanes_s;
  logic quad, multi, paused;
  logic sck_rise, sck_fall, cs_fall;
  assign sck_s = s2_r[0];
  assign cs_n_s = s2_r[1];
  assign lanes_s = s2_r[5:2];
  assign quad = (lane_mode_i == SFP_LANE_QUAD);
  assign multi = (lane_mode_i != SFP_LANE_SINGLE);
  // In quad mode the pause and protect pins are data lanes, not controls.
  assign pause_n_s = quad ? 1'b1 : s2_r[5];
  assign wp_n_s = quad ? 1'b1 : s2_r[4];
  assign paused = !cs_n_s && !pause_n_s;
  // Edges are found from the synchronised clock; both modes give the same edges.
  assign sck_rise = sck_s && !s3_r[0] && !paused;
  assign sck_fall = !sck_s && s3_r[0] && !paused;
  assign cs_fall = !cs_n_s && s3_r[1];

  // Arming, bit counting and the shift registers.
  logic armed_r, armed_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt;
  logic [3:0] out_r, out_nxt;
  logic rx_push, tx_pop, ovf_r, ovf_nxt, fifo_in_ready;
  logic [3:0] step;
  assign step = quad ? 4'h4 : (multi ? 4'h2 : 4'h1);

  always_comb begin
    armed_nxt = armed_r || cs_fall;
    cnt_nxt = cnt_r;
    rx_sh_nxt = rx_sh_r;
    tx_sh_nxt = tx_sh_r;
    out_nxt = out_r;
    rx_push = 1'b0;
    tx_pop = 1'b0;
    ovf_nxt = ovf_r && !cs_fall;
    if (cs_n_s) begin
      cnt_nxt = SFP_CNT_SEED;
    end else if (armed_r && sck_rise && !read_phase_i) begin
      case (lane_mode_i)
        SFP_LANE_QUAD: rx_sh_nxt = {rx_sh_r[3:0], lanes_s[3:0]};
        SFP_LANE_DUAL: rx_sh_nxt = {rx_sh_r[5:0], lanes_s[1:0]};
        default: rx_sh_nxt = {rx_sh_r[6:0], lanes_s[0]};
      endcase
      cnt_nxt = cnt_r + step;
      if (cnt_r + step == 4'(SFP_BYTE_BITS)) begin
        cnt_nxt = SFP_CNT_SEED;
        rx_push = 1'b1;
        // A lost byte sets the flag even when a select fall clears it in the same cycle.
        ovf_nxt = ovf_nxt || !fifo_in_ready;
      end
    end else if (armed_r && sck_fall && read_phase_i) begin
      // Load a fresh byte at a byte boundary, then shift out after each fall.
      if (cnt_r == SFP_CNT_SEED) begin
        tx_pop = tx_valid_i;
        tx_sh_nxt = tx_valid_i ? tx_data_i : 8'hff;
      end else begin
        tx_sh_nxt = tx_sh_r;
      end
      case (lane_mode_i)
        SFP_LANE_QUAD: out_nxt = (cnt_r == SFP_CNT_SEED) ? tx_sh_nxt[7:4] : tx_sh_r[3:0];
        SFP_LANE_DUAL: out_nxt = {2'h0, tx_sh_nxt[7 - cnt_r[2:0] -: 2]};
        default: out_nxt = {2'h0, tx_sh_nxt[7 - cnt_r[2:0]], 1'b0};
      endcase
      cnt_nxt = (cnt_r + step == 4'(SFP_BYTE_BITS)) ? SFP_CNT_SEED : cnt_r + step;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_r <= 1'b0;
      cnt_r <= SFP_CNT_SEED;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      out_r <= 4'h0;
      ovf_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
      cnt_r <= cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_sh_r <= tx_sh_nxt;
      out_r <= out_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // Received bytes queue here so the decoder may stall.
  sfp_fifo #(.WIDTH(SFP_BYTE_BITS), .DEPTH(SFP_FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_data_i(rx_sh_nxt),
    .in_valid_i(rx_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // Output enables: a lane drives only in a selected, unpaused read data phase.
  logic drive;
  assign drive = armed_r && !cs_n_s && !paused && read_phase_i;
  assign data_out_lane1_oe_o = drive && !quad_program_i;
  assign data_in_lane0_oe_o = drive && multi;
  assign write_protect_n_lane2_oe_o = drive && quad;
  assign pause_n_lane3_oe_o = drive && quad;
  assign data_out_lane1_o = out_r[1];
  assign data_in_lane0_o = out_r[0];
  assign write_protect_n_lane2_o = out_r[2];
  assign pause_n_lane3_o = out_r[3];

  assign tx_ready_o = tx_pop;
  assign rx_overflow_o = ovf_r;
  assign armed_o = armed_r;
  assign active_o = !cs_n_s || internal_busy_i;
  assign standby_o = cs_n_s && !internal_busy_i;
  assign program_blocked_o = !wp_n_s && (block_protect_field_i != SFP_BP_RESET);
  assign status_locked_o = !wp_n_s && srwd_i;

  // Checks on the front end; each guards the rule named at the end of its label line.
  a_arm_needs_fall: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(armed_r) |-> $past(cs_fall))
    else $error("Armed without select fall.");
  a_float_deselect: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cs_n_s |-> !data_out_lane1_oe_o && !data_in_lane0_oe_o && !write_protect_n_lane2_oe_o && !pause_n_lane3_oe_o)
    else $error("Lane driven while deselected.");
  a_float_pause: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    paused |-> !data_out_lane1_oe_o)
    else $error("Lane driven during pause.");
  a_pause_freezes: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    paused |=> $stable(rx_sh_r))
    else $error("Shift moved during pause.");
  a_lane0_single: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !multi |-> !data_in_lane0_oe_o)
    else $error("Lane 0 driven in single mode.");
  a_qpp_lane1_in: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    quad_program_i |-> !data_out_lane1_oe_o)
    else $error("Lane 1 driven in quad program.");
  a_standby_busy: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    internal_busy_i |-> !standby_o)
    else $error("Standby while busy.");
  a_byte_push: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    rx_push |-> cnt_r + step == 4'(SFP_BYTE_BITS))
    else $error("Push off a byte boundary.");
  // The receive shifter may only move on a rising edge seen at the synchronised clock pin.
  a_rise_sample: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !(s2_r[0] && !s3_r[0]) |=> $stable(rx_sh_r))
    else $error("Receive shifter moved off a rising edge.");
  a_wp_block: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!quad && !s2_r[4] && block_protect_field_i != 3'h0) |-> program_blocked_o)
    else $error("Protect not applied.");
  c_byte_in: cover property (@(posedge clk_i) disable iff (!reset_n_i) rx_push);
  c_dual_in: cover property (@(posedge clk_i) disable iff (!reset_n_i) rx_push && lane_mode_i == SFP_LANE_DUAL);
  c_quad_read: cover property (@(posedge clk_i) disable iff (!reset_n_i) quad && drive);
  c_pause: cover property (@(posedge clk_i) disable iff (!reset_n_i) paused);
  c_overflow: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(ovf_r));
endmodule : sfp_pins

// file: verification/sfp_host.sv
// Behavioural host controller: serial clock, select and four data lanes.
// Assumes the bench resolves shared lanes and calls these tasks after a clock edge.
`timescale 1ns/1ps
module sfp_host (
  input wire logic clk_i,
  input wire logic [3:0] q_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] d_o
);
  // Start deselected with the clock idle high as in mode 3.
  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    d_o = 4'h0;
  end
  // Select falling edge; the bench skips it only where it checks that traffic without one is ignored.
  task automatic sel();
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : sel
  // Park the clock at the idle level of the mode, then deselect.
  task automatic desel(input logic pol);
    sck_o <= pol;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : desel
  // One byte over w lanes, MSB first; 160 ns clock; lanes sampled late in the high phase.
  task automatic xfer(input int w, input logic [7:0] b, output logic [7:0] r);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    for (int e = 0; e < 8 / w; e++) begin
      sck_o <= 1'b0;
      d_o <= 4'(b >> (8 - w));
      b = b << w;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      r = (w == 1) ? {r[6:0], q_i[1]} : ((r << w) | 8'(q_i & m));
    end
  endtask : xfer
endmodule : sfp_host

// file: verification/testbench.sv
// Self-checking bench for the serial flash pin front end.
// Assumes the host model sfp_host and a 50 MHz system clock.
`timescale 1ns/1ps
module testbench;
  import sfp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] mode = 2'h0;
  logic rd = 1'b0, qp = 1'b0, busy = 1'b0, srwd = 1'b0, txv = 1'b0, rxr = 1'b0, pause_n = 1'b1, wp_n = 1'b1;
  logic [2:0] bp = 3'h0;
  logic [7:0] txd = 8'h00, r, rxd;
  wire [3:0] q, hd, o, oe;
  logic sck, cs_n, txr, rxv, ovf, armed, act, stby, blk, lck;
  int failures = 0;
  int checks = 0;
  int pops = 0;
  // System clock.
  always #10 clk_i = ~clk_i;
  // Counts bytes that the front end takes for sending.
  always @(posedge clk_i) begin
    if (txr === 1'b1) begin
      pops++;
    end
  end
  // Each lane shows the device while it drives, else the host or a control level.
  assign q[0] = oe[0] ? o[0] : hd[0];
  assign q[1] = oe[1] ? o[1] : hd[1];
  assign q[2] = oe[2] ? o[2] : (mode == 2'h2 ? hd[2] : wp_n);
  assign q[3] = oe[3] ? o[3] : (mode == 2'h2 ? hd[3] : pause_n);
  sfp_host host_u (.clk_i(clk_i), .q_i(q), .sck_o(sck), .cs_n_o(cs_n), .d_o(hd));
  sfp_pins dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .sck_i(sck), .cs_n_i(cs_n),
    .data_in_lane0_i(q[0]), .data_in_lane0_o(o[0]), .data_in_lane0_oe_o(oe[0]),
    .data_out_lane1_i(q[1]), .data_out_lane1_o(o[1]), .data_out_lane1_oe_o(oe[1]),
    .write_protect_n_lane2_i(q[2]), .write_protect_n_lane2_o(o[2]), .write_protect_n_lane2_oe_o(oe[2]),
    .pause_n_lane3_i(q[3]), .pause_n_lane3_o(o[3]), .pause_n_lane3_oe_o(oe[3]),
    .lane_mode_i(mode), .read_phase_i(rd), .quad_program_i(qp), .internal_busy_i(busy),
    .block_protect_field_i(bp), .srwd_i(srwd), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
    .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr), .rx_overflow_o(ovf), .armed_o(armed),
    .active_o(act), .standby_o(stby), .program_blocked_o(blk), .status_locked_o(lck));
  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Waits a bounded time for a received byte, compares it and pops it.
  task automatic get(input logic [7:0] e);
    int n;
    n = 0;
    while (rxv !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk(rxd === e && n < 50, "received byte");
    if (n == 50) tally_and_finish();
    rxr <= 1'b1;
    @(posedge clk_i);
    rxr <= 1'b0;
    @(posedge clk_i);
  endtask : get
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    host_u.xfer(1, 8'h11, r);
    chk(armed === 1'b0 && rxv === 1'b0 && oe === 4'h0, "traffic before select");
    host_u.sel();
    chk(armed === 1'b1 && stby === 1'b0 && act === 1'b1, "select arms");
    host_u.xfer(1, 8'ha5, r);
    get(8'ha5);
    host_u.desel(1'b0);
    host_u.sel();
    host_u.xfer(1, 8'h3c, r);
    get(8'h3c);
    pause_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    host_u.xfer(1, 8'hff, r);
    chk(rxv === 1'b0 && oe === 4'h0, "pause ignores clock");
    pause_n <= 1'b1;
    host_u.xfer(1, 8'h81, r);
    get(8'h81);
    txd <= 8'hc3;
    txv <= 1'b1;
    rd <= 1'b1;
    host_u.xfer(1, 8'h00, r);
    chk(r === 8'hc3 && oe === 4'h2, "single read");
    mode <= 2'h1;
    txd <= 8'h69;
    host_u.xfer(2, 8'h00, r);
    chk(r === 8'h69 && oe === 4'h3, "dual read");
    chk(pops == 2, "one byte taken per read");
    rd <= 1'b0;
    txv <= 1'b0;
    host_u.desel(1'b1);
    chk(oe === 4'h0, "deselect floats lanes");
    host_u.sel();
    host_u.xfer(2, 8'h96, r);
    get(8'h96);
    mode <= 2'h2;
    qp <= 1'b1;
    host_u.xfer(4, 8'h5a, r);
    get(8'h5a);
    chk(oe === 4'h0, "quad program lanes are inputs");
    qp <= 1'b0;
    mode <= 2'h0;
    host_u.desel(1'b1);
    host_u.sel();
    for (int i = 0; i <= SFP_FIFO_DEPTH; i++) host_u.xfer(1, 8'(i), r);
    chk(ovf === 1'b1, "overflow flagged");
    for (int i = 0; i < SFP_FIFO_DEPTH; i++) get(8'(i));
    chk(rxv === 1'b0, "buffer drained");
    host_u.desel(1'b1);
    host_u.sel();
    chk(ovf === 1'b0, "overflow cleared by select");
    host_u.desel(1'b1);
    busy <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(stby === 1'b0 && act === 1'b1, "busy holds off standby");
    busy <= 1'b0;
    wp_n <= 1'b0;
    bp <= 3'h4;
    srwd <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(stby === 1'b1 && act === 1'b0 && blk === 1'b1 && lck === 1'b1, "protect on");
    bp <= 3'h0;
    wp_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(blk === 1'b0 && lck === 1'b0, "protect off");
    // A select held low through a mid-run reset gives no falling edge and must not arm.
    host_u.sel();
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    host_u.xfer(1, 8'h11, r);
    chk(armed === 1'b0 && rxv === 1'b0 && act === 1'b1, "select held over reset");
    host_u.desel(1'b1);
    host_u.sel();
    host_u.xfer(1, 8'h24, r);
    get(8'h24);
    tally_and_finish();
  end
endmodule : testbench
